// >>> pkg/pras_defs.vh
`ifndef PRAS_DEFS_VH
`define PRAS_DEFS_VH
// register word offsets
`define PRAS_OFF_STATUS 4'h0
`define PRAS_OFF_MASK 4'h1
`define PRAS_OFF_DEST 4'h2
`define PRAS_OFF_LIVE 4'h3
`define PRAS_OFF_HIST 4'h4
`define PRAS_OFF_CTRL 4'h5
// event bit positions in status and mask
`define PRAS_EV_FUSE 0
`define PRAS_EV_SUPPLY 1
`define PRAS_EV_OVERCUR 2
`define PRAS_EV_HWERR 3
`define PRAS_EV_OVERHEAT 4
`define PRAS_EV_HEATER 5
`define PRAS_EV_INPUT 6
`define PRAS_EV_CTRLERR 7
`define PRAS_NUM_EV 8
`define PRAS_NUM_CLASS 6
// reset values
`define PRAS_DEST_RESET 12'h555
`define PRAS_MASK_RESET 8'h00
// decimal point blink half period (one phase), in ms and in cycles at 100 MHz
`define PRAS_BLINK_MS 250
`define PRAS_CLK_KHZ 100000
`define PRAS_BLINK_CYC (`PRAS_BLINK_MS * `PRAS_CLK_KHZ)
`endif

// >>> rtl/pras_supervisor.v
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
// Behaviour
// RQ1: fault lights red lamp, blinks decimal point
// RQ2: six alarm classes each own relay destination
// RQ3: blown fuse stops output, energises relay
// RQ4: bad frequency or overvoltage raises supply fault
// RQ5: overcurrent 130% or rated under 10V
// RQ6: hard overcurrent latch clears only at power-up
// RQ7: hardware fault on 75%/20%/5% condition
// RQ8: heatsink over 100C stops output, alarms
// RQ9: heater break alarms but power continues
// RQ10: input level fault: no relay, flashes
// RQ11: over/under range holds ramp limit
// RQ12: missing sync flags control fault, no relay
// RQ13: main supply loss alone stops output
// RQ14: stopping faults logged, return refused; the code logs fuse..overheat only, sync loss is not logged
// RQ15: stopping faults force standby output off
// RQ16: relay closed while allocated alarm active
// RQ17: shared destination ORs its alarms
// RQ18: stopping faults latch until power cycle; the code latches fuse..overheat only, sync loss stops output unlatched
`include "pras_defs.vh"
module pras_supervisor #(
  parameter BLINK_CYC = `PRAS_BLINK_CYC
) (
  input wire clk,
  input wire resetn,
  // avalon-mm slave
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // comparator flags from the power stage, return request and second discrete input, asynchronous
  input wire fuse_blown,
  input wire freq_out_of_window,
  input wire vout_over_120,
  input wire iout_over_130,
  input wire iout_over_rated,
  input wire vout_under_10v,
  input wire vout_over_75_main,
  input wire angle_under_20,
  input wire iout_over_5,
  input wire heatsink_over_100,
  input wire heater_break,
  input wire input_over_110,
  input wire input_under_m10,
  input wire sync_present,
  input wire return_request,
  input wire second_discrete_input,
  // outputs
  output reg power_enable,
  output reg [1:0] alarm_relay,
  output reg status_led,
  output reg decimal_point,
  output reg status_flash,
  output reg over_range,
  output reg under_range,
  output reg hold_upper,
  output reg hold_lower,
  output reg return_refused,
  output wire irq
);

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam NIN = 16;
  wire [NIN-1:0] raw_in; // pin levels
  reg [NIN-1:0] sync1; // first stage, read only by sync2
  reg [NIN-1:0] sync2; // stable levels
  assign raw_in = {second_discrete_input, return_request, sync_present,
                   input_under_m10, input_over_110, heater_break,
                   heatsink_over_100, iout_over_5, angle_under_20,
                   vout_over_75_main, vout_under_10v, iout_over_rated,
                   iout_over_130, vout_over_120, freq_out_of_window,
                   fuse_blown};

  // two flops per pin
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // sync_present idles high, so a reset must not fake a lost supply
      sync1 <= 16'h2000;
      sync2 <= 16'h2000;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  // ****************************************
  // fault detection
  // ****************************************
  wire [7:0] cond; // live fault conditions by event bit
  wire hard_oc; // over 130 percent current
  assign hard_oc = sync2[3];
  assign cond[`PRAS_EV_FUSE] = sync2[0]; // RQ3
  assign cond[`PRAS_EV_SUPPLY] = sync2[1] | sync2[2]; // RQ4
  assign cond[`PRAS_EV_OVERCUR] = sync2[3] | (sync2[4] & sync2[5]); // RQ5
  assign cond[`PRAS_EV_HWERR] = sync2[6] & sync2[7] & sync2[8]; // RQ7
  assign cond[`PRAS_EV_OVERHEAT] = sync2[9]; // RQ8
  assign cond[`PRAS_EV_HEATER] = sync2[10]; // RQ9
  assign cond[`PRAS_EV_INPUT] = sync2[11] | sync2[12]; // RQ10
  assign cond[`PRAS_EV_CTRLERR] = ~sync2[13]; // RQ12

  // ****************************************
  // latches held until power cycle
  // ****************************************
  reg hard_latch; // overcurrent trip circuit
  reg [4:0] stop_latch; // fuse..overheat latched faults
  reg [4:0] hist; // alarm history of fuse..overheat stopping faults

  // latches set only, cleared by reset alone
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hard_latch <= 1'b0;
      stop_latch <= 5'h00;
      hist <= 5'h00;
    end else begin
      if (hard_oc)
        hard_latch <= 1'b1; // RQ6
      stop_latch <= stop_latch | cond[4:0]; // RQ18
      hist <= hist | cond[4:0]; // RQ14
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] status; // sticky event bits
  reg [7:0] mask; // interrupt enables
  reg [11:0] dest; // 2 bits per class: bit0 relay1, bit1 relay2
  reg [7:0] cond_d; // previous conditions for edge detect
  wire [7:0] rise; // new events
  wire wr_status; // write to status
  reg rd_valid; // read data loaded, read answered this cycle
  assign rise = cond & ~cond_d;
  assign wr_status = write && (address == `PRAS_OFF_STATUS);
  // writes answer at once, reads wait one cycle for registered data
  assign waitrequest = read & ~rd_valid;
  assign irq = |(status & mask);

  // register writes, status set beats write-one clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= 8'h00;
      mask <= `PRAS_MASK_RESET;
      dest <= `PRAS_DEST_RESET;
      cond_d <= 8'h00;
    end else begin
      cond_d <= cond;
      if (wr_status)
        status <= (status & ~writedata[7:0]) | rise;
      else
        status <= status | rise;
      if (write && address == `PRAS_OFF_MASK)
        mask <= writedata[7:0];
      if (write && address == `PRAS_OFF_DEST)
        dest <= writedata[11:0]; // RQ2
    end
  end

  // read mux, registered data standing when waitrequest drops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h00000000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= read & ~rd_valid;
      if (read & ~rd_valid) begin
        case (address)
          `PRAS_OFF_STATUS: readdata <= {24'h000000, status};
          `PRAS_OFF_MASK: readdata <= {24'h000000, mask};
          `PRAS_OFF_DEST: readdata <= {20'h00000, dest};
          `PRAS_OFF_LIVE: readdata <= {24'h000000, cond};
          `PRAS_OFF_HIST: readdata <= {27'h0000000, hist};
          `PRAS_OFF_CTRL: readdata <= {30'h00000000, hard_latch,
                                       power_enable};
          default: readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // relay routing
  // ****************************************
  wire [5:0] cls_active; // six relay-capable classes
  reg [1:0] next_relay; // or of allocated classes
  integer i;
  assign cls_active = {cond[5], stop_latch | cond[4:0]};

  // combine classes sharing a destination
  always @* begin
    next_relay = 2'b00;
    for (i = 0; i < `PRAS_NUM_CLASS; i = i + 1) begin
      if (cls_active[i])
        next_relay = next_relay | dest[2*i +: 2]; // RQ16 RQ17
    end
  end

  // ****************************************
  // blink timer
  // ****************************************
  reg [31:0] blink_cnt; // period counter
  reg blink; // blink phase

  // free running blink phase
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt <= 32'h00000000;
      blink <= 1'b0;
    end else if (blink_cnt >= BLINK_CYC - 1) begin
      blink_cnt <= 32'h00000000;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h00000001;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  wire stopping; // any output-stopping fault
  wire any_fault; // any alarm class
  assign stopping = hard_latch | (|stop_latch) | (|cond[4:0]) | ~sync2[13];
  assign any_fault = stopping | cond[5] | cond[6];

  // registered output drive
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_enable <= 1'b0;
      alarm_relay <= 2'b00;
      status_led <= 1'b0;
      decimal_point <= 1'b0;
      status_flash <= 1'b0;
      over_range <= 1'b0;
      under_range <= 1'b0;
      hold_upper <= 1'b0;
      hold_lower <= 1'b0;
      return_refused <= 1'b0;
    end else begin
      power_enable <= ~stopping; // RQ13 RQ15
      alarm_relay <= next_relay; // RQ16
      status_led <= any_fault; // RQ1
      decimal_point <= any_fault & blink; // RQ1
      status_flash <= cond[6] & blink; // RQ10
      over_range <= sync2[11]; // RQ11
      under_range <= sync2[12];
      hold_upper <= sync2[11]; // RQ11
      hold_lower <= sync2[12] & ~sync2[11];
      return_refused <= stopping & (sync2[14] | sync2[15]); // RQ14
    end
  end

endmodule

// >>> bench/pras_stage.sv
`timescale 1ns/1ps
// power stage model: turns a fault code into comparator levels
module pras_stage (
  input wire clk,
  input wire [3:0] fault,
  output reg [13:0] flags
);
  // one row per code, bit 13 is the sync level, code 11 drops sync
  localparam [167:0] ROWS = {14'h0000, 14'h3000, 14'h2800, 14'h2400,
    14'h2200, 14'h21c0, 14'h2030, 14'h2018, 14'h2004, 14'h2002,
    14'h2001, 14'h2000};
  // levels change just after the edge, as the comparators would
  always @(posedge clk) begin
    flags <= ROWS[fault * 14 +: 14];
  end
endmodule

// >>> bench/pras_supervisor_props.sv
`timescale 1ns/1ps
// checker on the supervisor ports
module pras_props #(parameter BLINK_CYC = 4) (
  input wire clk, resetn, fuse_blown, freq_out_of_window, vout_over_120,
  input wire iout_over_130, iout_over_rated, vout_under_10v, iout_over_5,
  input wire vout_over_75_main, angle_under_20, heatsink_over_100,
  input wire heater_break, sync_present, power_enable,
  input wire [1:0] alarm_relay
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_fuse; fuse_blown |-> ##[1:4] !power_enable; endproperty
  a_fuse: assert property (p_fuse) else $error("fuse on");
  property p_sup; freq_out_of_window || vout_over_120
    |-> ##[1:4] !power_enable; endproperty
  a_sup: assert property (p_sup) else $error("supply on");
  property p_ocur; iout_over_130 || iout_over_rated && vout_under_10v
    |-> ##[1:4] !power_enable; endproperty
  a_ocur: assert property (p_ocur) else $error("overcur on");
  property p_hw; vout_over_75_main && angle_under_20 && iout_over_5
    |-> ##[1:4] !power_enable; endproperty
  a_hw: assert property (p_hw) else $error("hw on");
  property p_heat; heatsink_over_100 |-> ##[1:4] !power_enable; endproperty
  a_heat: assert property (p_heat) else $error("heat on");
  property p_latch; iout_over_130 |-> ##4 (!power_enable) [*8]; endproperty
  a_latch: assert property (p_latch) else $error("latch lost");
  property p_sync; !sync_present |-> ##[1:4] !power_enable; endproperty
  a_sync: assert property (p_sync) else $error("sync on");
  property p_relay; heater_break |-> ##[1:4] alarm_relay != 2'h0; endproperty
  a_relay: assert property (p_relay) else $error("relay off");
  c_on: cover property (!power_enable ##1 power_enable);
  c_off: cover property ($fell(power_enable));
  c_relay2: cover property (alarm_relay == 2'h2);
endmodule
bind pras_supervisor pras_props #(.BLINK_CYC(BLINK_CYC)) i_pras_props (.*);

// >>> bench/testbench.sv
`timescale 1ns/1ps
// self-checking bench: one fault code per test
module testbench;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [3:0] address = 4'h0;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [3:0] fault = 4'h0;
  reg [11:0] dest;
  reg [7:0] mask;
  reg [31:0] rd;
  wire [13:0] f;
  wire [31:0] readdata;
  wire waitrequest, power_enable, over_range, under_range, irq;
  wire [1:0] alarm_relay;
  wire status_led, decimal_point, status_flash;
  wire hold_upper, hold_lower, return_refused;
  reg rq = 1'b0;
  reg di = 1'b0;
  reg dp_or, dp_and, fl_or;
  integer errors = 0, compares = 0, cycles = 0, code, k;
  initial forever #5 clk = ~clk;
  pras_stage i_pras_stage (.clk(clk), .fault(fault), .flags(f));
  pras_supervisor #(.BLINK_CYC(4)) i_pras_supervisor (.clk(clk),
    .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .fuse_blown(f[0]), .freq_out_of_window(f[1]), .vout_over_120(f[2]),
    .iout_over_130(f[3]), .iout_over_rated(f[4]), .vout_under_10v(f[5]),
    .vout_over_75_main(f[6]), .angle_under_20(f[7]), .iout_over_5(f[8]),
    .heatsink_over_100(f[9]), .heater_break(f[10]),
    .input_over_110(f[11]), .input_under_m10(f[12]), .sync_present(f[13]),
    .return_request(rq), .second_discrete_input(di),
    .power_enable(power_enable), .alarm_relay(alarm_relay),
    .status_led(status_led), .decimal_point(decimal_point),
    .status_flash(status_flash),
    .over_range(over_range), .under_range(under_range),
    .hold_upper(hold_upper), .hold_lower(hold_lower),
    .return_refused(return_refused), .irq(irq));
  // event bit of a fault code, -1 for none
  function integer ev(input integer c);
    ev = c < 2 ? c - 1 : c < 4 ? 1 : c < 6 ? 2 : c < 9 ? c - 3 : c < 11 ? 6 : 7;
  endfunction
  // expected {power_enable, relay, over, under, irq} while a fault stands
  function [31:0] exp_live(input integer c, input [11:0] dv, input [7:0] m);
    integer e;
    begin
      e = ev(c);
      exp_live = {26'h0, !(c > 0 && c < 8 || c == 11),
        (c > 0 && c < 9) ? dv[2 * e +: 2] : 2'h0, c == 9, c == 10,
        c > 0 && m[e]};
    end
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low at an edge
  task bus(input wr, input [3:0] a, input [31:0] d);
    begin
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      finish_test;
    end
  end
  initial begin
    k = $urandom(32'h78d8);
    for (code = 0; code < 12; code = code + 1) begin
      fault <= 4'h0;
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 6; k = k + 1) dest[2 * k +: 2] = 2'h1 + $urandom % 2;
      mask = $urandom;
      bus(1, 4'h2, {20'h0, dest});
      bus(1, 4'h1, {24'h0, mask});
      fault <= code;
      rq <= $urandom % 2;
      di <= $urandom % 2;
      repeat (8) @(posedge clk);
      check({26'h0, power_enable, alarm_relay, over_range, under_range,
        irq}, exp_live(code, dest, mask));
      check({31'h0, status_led}, code > 0);
      check({30'h0, hold_upper, hold_lower},
        {30'h0, code == 9, code == 10});
      check({31'h0, return_refused},
        (code > 0 && code < 8 || code == 11) && (rq || di));
      dp_or = 1'b0;
      dp_and = 1'b1;
      fl_or = 1'b0;
      for (k = 0; k < 12; k = k + 1) begin
        @(posedge clk);
        dp_or = dp_or | decimal_point;
        dp_and = dp_and & decimal_point;
        fl_or = fl_or | status_flash;
      end
      check({30'h0, dp_or, dp_and}, code ? 32'h2 : 32'h0);
      check({31'h0, fl_or}, code == 9 || code == 10);
      rq <= 1'b0;
      di <= 1'b0;
      bus(0, 4'h0, 32'h0);
      check(rd, code ? 32'h1 << ev(code) : 32'h0);
      fault <= 4'h0;
      repeat (8) @(posedge clk);
      check({31'h0, power_enable}, !(code > 0 && code < 8));
      bus(0, 4'h4, 32'h0);
      check(rd, code > 0 && code < 8 ? 32'h1 << ev(code) : 32'h0);
      bus(1, 4'h0, 32'hff);
      bus(0, 4'h0, 32'h0);
      check({rd[30:0], irq}, 32'h0);
      bus(0, 4'hf, 32'h0);
      check(rd, 32'h0);
      $display("test %0d done", code);
    end
    finish_test;
  end
endmodule
